// File: logic/tmra_timer.v
// Eight-bit up timer with auto-reload, request flag and tone output.
// What this block does
// - With tone output enabled the overflow toggle drives the tone pin and the pin's GPIO function is cut off.
// - The tone pin toggles on each overflow, so its frequency is half the overflow frequency.
// - With auto-reload enabled the count reloads from the reload value on overflow.
// - A serviced timer interrupt sends the processor to program address 8.
// - With fast clock select at 0, prescale code 110 counts at CPU clock over 4.
// - The request reaches the processor only while the interrupt enable is set.
// - The count increments once per prescaled pulse and FFH to 00H sets the flag.
// - The reload value is write-only and feeds the count on overflow under auto-reload.
`default_nettype none
`include "tmra_defines.vh"
module tmra_timer (
   // Clock and reset
   input  wire        mclk,
   input  wire        reset,
   // Mode control
   input  wire        timer_run_bit,
   input  wire        fast_clock_select,
   input  wire [2:0]  prescale_select,
   input  wire        auto_reload_enable,
   input  wire        tone_out_enable,
   input  wire        timer_irq_enable,
   // Count and reload writes
   input  wire        count_wr,
   input  wire [7:0]  count_wdata,
   input  wire        reload_wr,
   input  wire [7:0]  reload_wdata,
   // Request flag clear by software
   input  wire        irq_flag_clr,
   // GPIO path of the shared pin
   input  wire        gpio_out,
   input  wire        gpio_oe,
   // Status
   output reg  [7:0]  timer_count_reg,
   output reg         timer_irq_flag_reg,
   output reg         irq_req_reg,
   output reg  [11:0] irq_vector_reg,
   // Shared pin
   output reg         tone_pin_out_reg,
   output reg         tone_pin_oe_reg
);
   wire       tick;
   reg  [7:0] reload_value_reg;
   reg        tone_level_reg;
   wire       overflow;

   tmra_prescaler u_pre (
      .mclk              (mclk),
      .reset             (reset),
      .run               (timer_run_bit),
      .fast_clock_select (fast_clock_select),
      .prescale_select   (prescale_select),
      .tick_reg          (tick)
   );

   assign overflow = timer_run_bit && tick &&
                     (timer_count_reg == `TMRA_COUNT_MAX);

   // The reload value has no read path at all.
   always @(posedge mclk or posedge reset) begin
      if (reset)
         reload_value_reg <= `TMRA_RELOAD_RST;
      else if (reload_wr)
         reload_value_reg <= reload_wdata;
   end

   // A software write to the count wins over a tick in the same cycle.
   always @(posedge mclk or posedge reset) begin
      if (reset)
         timer_count_reg <= `TMRA_COUNT_RST;
      else if (count_wr)
         timer_count_reg <= count_wdata;
      else if (overflow && auto_reload_enable)
         timer_count_reg <= reload_value_reg;
      else if (timer_run_bit && tick)
         timer_count_reg <= timer_count_reg + 8'h01;
   end

   // Set beats clear so an overflow in the clearing cycle is kept.
   always @(posedge mclk or posedge reset) begin
      if (reset)
         timer_irq_flag_reg <= 1'b0;
      else if (overflow)
         timer_irq_flag_reg <= 1'b1;
      else if (irq_flag_clr)
         timer_irq_flag_reg <= 1'b0;
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq_req_reg    <= 1'b0;
         irq_vector_reg <= `TMRA_IRQ_VECTOR;
      end else begin
         irq_req_reg    <= timer_irq_flag_reg && timer_irq_enable;
         irq_vector_reg <= `TMRA_IRQ_VECTOR;
      end
   end

   always @(posedge mclk or posedge reset) begin
      if (reset)
         tone_level_reg <= 1'b0;
      else if (!tone_out_enable)
         tone_level_reg <= 1'b0;
      else if (overflow)
         tone_level_reg <= ~tone_level_reg;
   end

   // Pin mux is registered; the GPIO path lags one cycle as a result.
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         tone_pin_out_reg <= 1'b0;
         tone_pin_oe_reg  <= 1'b0;
      end else if (tone_out_enable) begin
         tone_pin_out_reg <= tone_level_reg;
         tone_pin_oe_reg  <= 1'b1;
      end else begin
         tone_pin_out_reg <= gpio_out;
         tone_pin_oe_reg  <= gpio_oe;
      end
   end
endmodule // tmra_timer
`default_nettype wire

// File: logic/tmra_defines.vh
// Constants for the eight-bit auto-reload timer with tone output.
`ifndef TMRA_DEFINES_VH
`define TMRA_DEFINES_VH
`define TMRA_COUNT_MAX      8'hFF
`define TMRA_COUNT_ZERO     8'h00
`define TMRA_COUNT_RST      8'h00
`define TMRA_RELOAD_RST     8'h00
`define TMRA_RATE_RST       3'h0
`define TMRA_IRQ_VECTOR     12'h008
`define TMRA_VECTOR_W       12
`define TMRA_RATE_W         3
`define TMRA_RATE_DIV4      3'h6
`define TMRA_PRE_W          8
`endif

// File: logic/tmra_prescaler.v
// Prescaler that turns the CPU clock into the timer's count enable pulse.
`default_nettype none
`include "tmra_defines.vh"
module tmra_prescaler (
   // Clock and reset
   input  wire       mclk,
   input  wire       reset,
   // Control
   input  wire       run,
   input  wire       fast_clock_select,
   input  wire [2:0] prescale_select,
   // Count enable
   output reg        tick_reg
);
   reg [`TMRA_PRE_W-1:0] div_reg;
   reg [`TMRA_PRE_W-1:0] mask;

   // Slow mode divides by 2^(8-code): code 110 gives a divide by 4.
   // Fast mode divides eight times less, down to the raw clock.
   always @* begin
      mask = (8'hFF >> prescale_select);
      if (fast_clock_select)
         mask = mask >> 3;
   end

   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         div_reg  <= 8'h00;
         tick_reg <= 1'b0;
      end else if (!run) begin
         div_reg  <= 8'h00;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= (div_reg + 8'h01) & mask;
         tick_reg <= ((div_reg & mask) == mask);
      end
   end
endmodule // tmra_prescaler
`default_nettype wire

// File: testbench/tmra_timer_monitor.sv
// Assertion checker for the tone timer.
`default_nettype none
module tmra_timer_monitor (
   // Watched ports
   input wire logic mclk,
   input wire logic reset,
   input wire logic timer_run_bit,
   input wire logic fast_clock_select,
   input wire logic [2:0] prescale_select,
   input wire logic auto_reload_enable,
   input wire logic tone_out_enable,
   input wire logic timer_irq_enable,
   input wire logic count_wr,
   input wire logic reload_wr,
   input wire logic [7:0] reload_wdata,
   input wire logic gpio_oe,
   input wire logic [7:0] timer_count_reg,
   input wire logic timer_irq_flag_reg,
   input wire logic irq_req_reg,
   input wire logic [11:0] irq_vector_reg,
   input wire logic tone_pin_out_reg,
   input wire logic tone_pin_oe_reg);
   // The reload value is write-only, so a shadow stands in for it.
   logic [7:0] rl_reg;
   always_ff @(posedge mclk or posedge reset)
      if (reset) rl_reg <= 8'h00;
      else if (reload_wr) rl_reg <= reload_wdata;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_tick;
      $changed(timer_count_reg) && !$past(count_wr) && !count_wr;
   endsequence
   sequence s_ovf;
      s_tick ##0 $past(timer_count_reg) == 8'hFF;
   endsequence
   sequence s_div4;
      timer_run_bit && !fast_clock_select && prescale_select == 3'h6 &&
         !count_wr;
   endsequence
   AST_FLAG: assert property (s_ovf |-> timer_irq_flag_reg)
      else $error("flag not set");
   AST_WRAP: assert property (s_ovf ##0 !$past(auto_reload_enable)
      |-> timer_count_reg == 8'h00) else $error("no wrap");
   AST_LOAD: assert property (s_ovf ##0 $past(auto_reload_enable)
      |-> timer_count_reg == $past(rl_reg)) else $error("no reload");
   AST_REQ: assert property (1'b1 |=> irq_req_reg ==
      ($past(timer_irq_flag_reg) && $past(timer_irq_enable)))
      else $error("bad request");
   AST_VEC: assert property (irq_vector_reg == 12'h008)
      else $error("bad vector");
   AST_TONE: assert property (s_ovf ##0 (tone_out_enable &&
      $past(tone_out_enable)) ##1 tone_out_enable
      |-> $changed(tone_pin_out_reg)) else $error("no toggle");
   AST_PIN: assert property (1'b1 |=> tone_pin_oe_reg ==
      ($past(tone_out_enable) || $past(gpio_oe))) else $error("bad pin");
   AST_RATE: assert property (s_tick ##0 s_div4 ##1 s_div4 [*4]
      |-> $changed(timer_count_reg) &&
      $past(timer_count_reg) == $past(timer_count_reg, 4))
      else $error("bad rate");
endmodule // tmra_timer_monitor
bind tmra_timer tmra_timer_monitor tmra_timer_monitor_inst (.*);
`default_nettype wire

// File: testbench/tmra_timer_tb.sv
// Testbench for the tone timer.
`default_nettype none
module tmra_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'h0, reset, timer_run_bit, fast_clock_select, count_wr;
   logic auto_reload_enable, tone_out_enable, timer_irq_enable, reload_wr;
   logic irq_flag_clr, gpio_out, gpio_oe, timer_irq_flag_reg, irq_req_reg;
   logic tone_pin_out_reg, tone_pin_oe_reg;
   logic [2:0] prescale_select;
   logic [7:0] count_wdata, reload_wdata, timer_count_reg;
   logic [11:0] irq_vector_reg;
   int n_fail = 0, n_checks = 0;
   tmra_timer tmra_timer_inst (.*);
   initial forever #2 mclk = ~mclk;
   task automatic chk(input logic [11:0] got, exp);
      n_checks++;
      if (got !== exp) n_fail++;
      if (got !== exp) $display("[ERR] %0t %h %h", $time, got, exp);
   endtask
   task automatic give_verdict();
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic ovf();
      @(negedge mclk) irq_flag_clr = 1'h1;
      @(negedge mclk) irq_flag_clr = 1'h0;
      chk(timer_irq_flag_reg, 1'h0);
      for (int i = 0; i < 40 && timer_irq_flag_reg !== 1'h1; i++)
         @(negedge mclk);
      @(negedge mclk);
      chk(timer_irq_flag_reg, 1'h1);
   endtask
   task automatic arm(input logic [3:0] mode, input logic [7:0] v);
      @(negedge mclk) {timer_run_bit, count_wr, reload_wr} = 3'h3;
      {count_wdata, reload_wdata} = {v, v};
      @(negedge mclk) {count_wr, reload_wr} = 2'h0;
      {timer_run_bit, auto_reload_enable, tone_out_enable,
         timer_irq_enable} = mode;
      ovf();
   endtask
   task automatic t_wrap();
      arm(4'h9, 8'hFE);
      chk(timer_count_reg, 8'h00);
      chk(irq_req_reg, 1'h1);
      @(negedge mclk) timer_irq_enable = 1'h0;
      @(negedge mclk) chk(irq_req_reg, 1'h0);
      @(negedge mclk) {count_wr, count_wdata} = {1'h1, 8'h74};
      @(negedge mclk) count_wr = 1'h0;
      chk(timer_count_reg, 8'h74);
   endtask
   task automatic t_reload();
      arm(4'hF, 8'hFC);
      chk(timer_count_reg, 8'hFC);
      chk({tone_pin_oe_reg, tone_pin_out_reg}, 2'h3);
      ovf();
      chk(tone_pin_out_reg, 1'h0);
      {tone_out_enable, gpio_out, gpio_oe} = 3'h2;
      @(negedge mclk) chk({tone_pin_oe_reg, tone_pin_out_reg}, 2'h1);
   endtask
   initial begin
      {reset, timer_run_bit, fast_clock_select, auto_reload_enable,
         tone_out_enable, timer_irq_enable, count_wr, reload_wr} = 8'h80;
      {irq_flag_clr, gpio_out, gpio_oe, prescale_select} = 6'h06;
      {count_wdata, reload_wdata} = 16'h0000;
      repeat (5) @(posedge mclk);
      @(negedge mclk) reset = 1'h0;
      chk(irq_vector_reg, 12'h008);
      t_wrap();
      t_reload();
      give_verdict();
   end
   // A full pass needs under a hundred cycles, so a thousand means a hang.
   initial begin
      #4000;
      n_fail++;
      give_verdict();
   end
endmodule // tmra_timer_tb
`default_nettype wire
